// ### inc/dsrl_pkg.sv
// ----------------------------------------------------------------------
// Constants for the software request logic of the two-channel DMA.
// ----------------------------------------------------------------------
package dsrl_pkg;

    // ------------------------------------------------------------------
    // Bus widths and channel count.
    // ------------------------------------------------------------------
    localparam int DSRL_AW     = 16;
    localparam int DSRL_DW     = 8;
    localparam int DSRL_NUM_CH = 2;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [15:0] DSRL_SRR_OFF  = 16'hf009; // Software request.
    localparam logic [15:0] DSRL_CFG_OFF  = 16'hf0c0; // Channel options.
    localparam logic [15:0] DSRL_STAT_OFF = 16'hf0c1; // Arbiter state.

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int DSRL_SRR_CS_POS   = 0; // Channel select.
    localparam int DSRL_SRR_REQ_POS  = 2; // Request bit.
    localparam int DSRL_CFG_AUTO_POS = 0; // Auto-initialize.
    localparam int DSRL_CFG_DEM_POS  = 1; // Demand mode, two bits.
    localparam int DSRL_CFG_MSK_POS  = 3; // Hardware mask, two bits.
    localparam int DSRL_STAT_LST_POS = 2; // Channel served last.

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] DSRL_SRR_RST = 8'h00;
    localparam logic [7:0] DSRL_CFG_RST = 8'h18; // Hardware masked.

    // ------------------------------------------------------------------
    // Arbiter states.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DSRL_IDLE  = 3'b001,
        DSRL_SERV0 = 3'b010,
        DSRL_SERV1 = 3'b100
    } dsrl_state_e;

    // Address match, shared by every decode in the block.
    function automatic logic dsrl_hit(input logic [15:0] addr,
                                      input logic [15:0] off);
        dsrl_hit = (addr == off);
    endfunction

endpackage

// ### logic/dsrl_chan.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// One channel: pending software request flag and internal request.
// ----------------------------------------------------------------------
module dsrl_chan
    import dsrl_pkg::*;
(
    input  wire logic clk,      // System clock.
    input  wire logic rst,      // Asynchronous reset, active high.
    input  wire logic sw_set,   // Software request written.
    input  wire logic done,     // Buffer transfer of this channel ended.
    input  wire logic clr_all,  // Auto-initialize clear of both flags.
    input  wire logic hw_req,   // Hardware request line.
    input  wire logic hw_mask,  // Hardware request masked.
    output logic      pend,     // Software request pending.
    output logic      ch_req    // Internal channel request.
);

    logic pend_ff;

    // A set beats a clear in the same cycle so no request is lost;
    // a second set while pending leaves one request, no queue.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_ff <= 1'b0;
        end else if (sw_set) begin
            pend_ff <= 1'b1;
        end else if (done || clr_all) begin
            pend_ff <= 1'b0;
        end
    end

    // The mask gates only the hardware line, never software requests.
    assign ch_req = pend_ff | (hw_req & ~hw_mask);
    assign pend   = pend_ff;

endmodule

// ### logic/dsrl_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Request bit 2 set in a write raises the selected channel's request.
// - Select bit 0 routes the request to channel 0 or channel 1.
// - Software and hardware requests arbitrate on equal terms for the bus.
// - A software request asserts the channel's internal request signal.
// - That request holds until terminal count or end of process.
// - In demand mode a deasserted request suspends the transfer.
// - A channel's request bit clears itself when its transfer completes.
// - Reading shows pending flags: bit 1 channel 1, bit 0 channel 0.
// - Pending flag clears on terminal count or end-of-process input.
// - In auto-initialize mode one end clears both pending flags.
// - After reset the read view returns 00H.
// - Masked hardware requests do not block software requests.
module dsrl_top
    import dsrl_pkg::*;
#(
    parameter int NUM_CH = DSRL_NUM_CH
)
(
    input  wire logic        CLK_SYS,          // System clock, 50 MHz.
    input  wire logic        RESET,            // Async reset, active high.
    input  wire logic [15:0] ADDR,             // Register address.
    input  wire logic [7:0]  WDATA,            // Register write data.
    input  wire logic        WR,               // Write strobe.
    input  wire logic        RD,               // Read strobe.
    output logic      [7:0]  RDATA,            // Read data, next cycle.
    input  wire logic [1:0]  DREQ,             // Hardware requests.
    input  wire logic [1:0]  TC,               // Terminal count pulses.
    input  wire logic        END_OF_PROCESS_N, // External end, active low.
    output logic      [1:0]  CH_REQ,           // Internal requests.
    output logic      [1:0]  GRANT             // Channel holding the bus.
);

    // ------------------------------------------------------------------
    // Elaboration check.
    // ------------------------------------------------------------------
    // The register layout carries exactly two channel flags.
    if (NUM_CH != 2) begin : g_bad_ch
        $error("dsrl_top serves exactly two channels");
    end

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    dsrl_state_e state_ff;
    dsrl_state_e nxt_state;
    logic [7:0]  cfg_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        last_ff;
    logic        nxt_last;
    logic        wr_srr;
    logic        wr_cfg;
    logic        ext_end;
    logic        auto_init;
    logic        clr_all;
    logic [1:0]  demand;
    logic [1:0]  hw_mask;
    logic [1:0]  sw_set;
    logic [1:0]  done;
    logic [1:0]  pend;
    logic [1:0]  ch_req;
    logic [1:0]  serving;

    // ------------------------------------------------------------------
    // Register decode.
    // ------------------------------------------------------------------
    // Write decodes; bits 7-3 and bit 1 of the request write are
    // ignored, so software garbage there cannot alter any flag.
    always_comb begin
        wr_srr = 1'b0;
        wr_cfg = 1'b0;
        if (WR && dsrl_hit(ADDR, DSRL_SRR_OFF)) begin
            wr_srr = 1'b1;
        end else if (WR && dsrl_hit(ADDR, DSRL_CFG_OFF)) begin
            wr_cfg = 1'b1;
        end
    end

    // Channel options written by software.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cfg_ff <= DSRL_CFG_RST;
        end else if (wr_cfg) begin
            cfg_ff <= WDATA;
        end
    end

    assign auto_init = cfg_ff[DSRL_CFG_AUTO_POS];
    assign demand    = cfg_ff[DSRL_CFG_DEM_POS +: 2];
    assign hw_mask   = cfg_ff[DSRL_CFG_MSK_POS +: 2];

    // ------------------------------------------------------------------
    // Software request routing and end of transfer.
    // ------------------------------------------------------------------
    // The select bit steers the request bit to one channel only.
    assign sw_set[0] = wr_srr && WDATA[DSRL_SRR_REQ_POS]
                       && !WDATA[DSRL_SRR_CS_POS];
    assign sw_set[1] = wr_srr && WDATA[DSRL_SRR_REQ_POS]
                       && WDATA[DSRL_SRR_CS_POS];

    // The external end applies to whichever channel holds the bus; an
    // end seen while idle has no transfer to finish and is dropped.
    assign ext_end    = !END_OF_PROCESS_N;
    assign serving[0] = (state_ff == DSRL_SERV0);
    assign serving[1] = (state_ff == DSRL_SERV1);
    assign done[0]    = serving[0] && (TC[0] || ext_end);
    assign done[1]    = serving[1] && (TC[1] || ext_end);
    assign clr_all    = auto_init && (done != 2'b00);

    // ------------------------------------------------------------------
    // Channels.
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        dsrl_chan u_chan (
            .clk     (CLK_SYS),
            .rst     (RESET),
            .sw_set  (sw_set[i]),
            .done    (done[i]),
            .clr_all (clr_all),
            .hw_req  (DREQ[i]),
            .hw_mask (hw_mask[i]),
            .pend    (pend[i]),
            .ch_req  (ch_req[i])
        );
    end

    // ------------------------------------------------------------------
    // Priority arbiter.
    // ------------------------------------------------------------------
    // Rotating priority: software and hardware requests look alike to
    // the arbiter, so neither source can starve the other channel.
    always_comb begin
        nxt_state = state_ff;
        nxt_last  = last_ff;
        case (state_ff)
            DSRL_IDLE: begin
                if (ch_req == 2'b11) begin
                    nxt_state = last_ff ? DSRL_SERV0 : DSRL_SERV1;
                    nxt_last  = !last_ff;
                end else if (ch_req[0]) begin
                    nxt_state = DSRL_SERV0;
                    nxt_last  = 1'b0;
                end else if (ch_req[1]) begin
                    nxt_state = DSRL_SERV1;
                    nxt_last  = 1'b1;
                end
            end
            DSRL_SERV0: begin
                if (done[0]) begin
                    nxt_state = DSRL_IDLE;
                end else if (demand[0] && !ch_req[0]) begin
                    nxt_state = DSRL_IDLE;
                end
            end
            DSRL_SERV1: begin
                if (done[1]) begin
                    nxt_state = DSRL_IDLE;
                end else if (demand[1] && !ch_req[1]) begin
                    nxt_state = DSRL_IDLE;
                end
            end
            default: begin
                nxt_state = DSRL_IDLE;
            end
        endcase
    end

    // Arbiter state.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_ff <= DSRL_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Channel served last; reset favours channel 0 on the first tie.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            last_ff <= 1'b1;
        end else begin
            last_ff <= nxt_last;
        end
    end

    // ------------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------------
    // Read data stand for one cycle only and are zero otherwise, so a
    // stale value can never be mistaken for a fresh answer.
    always_comb begin
        nxt_rdata = 8'h00;
        if (RD && dsrl_hit(ADDR, DSRL_SRR_OFF)) begin
            nxt_rdata = {6'h00, pend};
        end else if (RD && dsrl_hit(ADDR, DSRL_CFG_OFF)) begin
            nxt_rdata = cfg_ff;
        end else if (RD && dsrl_hit(ADDR, DSRL_STAT_OFF)) begin
            nxt_rdata = {5'h00, last_ff, serving};
        end
    end

    // Registered read data.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            rdata_ff <= DSRL_SRR_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA  = rdata_ff;
    assign CH_REQ = ch_req;
    assign GRANT  = serving;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    sequence s_req_ch0;
        wr_srr && WDATA[DSRL_SRR_REQ_POS] && !WDATA[DSRL_SRR_CS_POS];
    endsequence

    sequence s_req_ch1;
        wr_srr && WDATA[DSRL_SRR_REQ_POS] && WDATA[DSRL_SRR_CS_POS];
    endsequence

    sequence s_read_srr;
        RD && dsrl_hit(ADDR, DSRL_SRR_OFF);
    endsequence

    sequence s_tie_idle;
        (state_ff == DSRL_IDLE) && (CH_REQ == 2'b11);
    endsequence

    property p_set_ch0;
        s_req_ch0 |=> pend[0] && (CH_REQ[0] == 1'b1);
    endproperty
    a_set_ch0: assert property (p_set_ch0)
        else $error("channel 0 request not raised");

    property p_route_ch1;
        s_req_ch1 ##0 (!done[0] && !clr_all)
            |=> pend[1] && (pend[0] == $past(pend[0]));
    endproperty
    a_route_ch1: assert property (p_route_ch1)
        else $error("channel 1 request misrouted");

    property p_tie_rotates;
        s_tie_idle |=> (GRANT[0] == $past(last_ff))
                       && (GRANT[1] == !$past(last_ff));
    endproperty
    a_tie_rotates: assert property (p_tie_rotates)
        else $error("tie not resolved by rotation");

    property p_pend_drives_req;
        pend[1] |-> CH_REQ[1];
    endproperty
    a_pend_drives_req: assert property (p_pend_drives_req)
        else $error("pending request not driving channel request");

    property p_hold_until_end;
        (pend[0] && !done[0] && !clr_all) |=> pend[0] [*1];
    endproperty
    a_hold_until_end: assert property (p_hold_until_end)
        else $error("request dropped before end of transfer");

    property p_demand_suspend;
        (GRANT[0] && demand[0] && !CH_REQ[0] && !done[0])
            |=> (GRANT == 2'b00) ##1 (GRANT[1] == $past(CH_REQ[1]));
    endproperty
    a_demand_suspend: assert property (p_demand_suspend)
        else $error("demand transfer not suspended");

    property p_clear_on_end;
        (GRANT[1] && (TC[1] || !END_OF_PROCESS_N) && !sw_set[1])
            |=> !pend[1] && (GRANT == 2'b00);
    endproperty
    a_clear_on_end: assert property (p_clear_on_end)
        else $error("pending flag not cleared at end");

    property p_read_view;
        s_read_srr |=> RDATA == {6'h00, $past(pend)};
    endproperty
    a_read_view: assert property (p_read_view)
        else $error("request register read mismatch");

    property p_read_quiet;
        !RD |=> RDATA == 8'h00;
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read data not zero outside a read");

    property p_auto_both;
        (clr_all && (sw_set == 2'b00)) |=> (pend == 2'b00);
    endproperty
    a_auto_both: assert property (p_auto_both)
        else $error("auto-initialize did not clear both flags");

    property p_masked_sw;
        s_req_ch0 ##0 hw_mask[0] |=> CH_REQ[0];
    endproperty
    a_masked_sw: assert property (p_masked_sw)
        else $error("masked channel refused software request");

    property p_no_queue;
        pend[1] ##0 s_req_ch1 ##1 (done[1] && !sw_set[1])
            |=> !pend[1];
    endproperty
    a_no_queue: assert property (p_no_queue)
        else $error("second request was queued");

    property p_no_spurious;
        (!pend[0] && !sw_set[0]) |=> !pend[0];
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("pending flag set without a request");

    // An end while channel 0 holds the bus clears its flag and the grant.
    property p_clear_ch0;
        (GRANT[0] && (TC[0] || !END_OF_PROCESS_N) && !sw_set[0])
            |=> !pend[0] && (GRANT == 2'b00);
    endproperty
    a_clear_ch0: assert property (p_clear_ch0)
        else $error("channel 0 flag not cleared at end");

    // A grant to channel 1 is only ever given when channel 1 was requesting.
    property p_grant_needs_req;
        $rose(GRANT[1]) |-> $past(CH_REQ[1]);
    endproperty
    a_grant_needs_req: assert property (p_grant_needs_req)
        else $error("grant given without a request");

    // The status view shows the grant and the channel served last.
    property p_stat_view;
        RD && dsrl_hit(ADDR, DSRL_STAT_OFF)
            |=> RDATA == {5'h00, $past(last_ff), $past(GRANT)};
    endproperty
    a_stat_view: assert property (p_stat_view)
        else $error("status read mismatch");

    // The first cycle out of reset shows an empty read view.
    property p_reset_view;
        $fell(RESET) |-> (RDATA == 8'h00) && (pend == 2'b00);
    endproperty
    a_reset_view: assert property (p_reset_view)
        else $error("read view not empty after reset");

endmodule

// ### bench/dsrl_engine.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Behavioural transfer engine at the far side of the arbiter.
// ----------------------------------------------------------------------
module dsrl_engine #(
    parameter int LEN = 4
)
(
    input  wire logic       clk,     // System clock.
    input  wire logic       rst,     // Reset, active high.
    input  wire logic [1:0] grant,   // Channel holding the bus.
    input  wire logic       hold,    // Stall the buffer transfer.
    input  wire logic       use_eop, // End by end of process, not count.
    output logic      [1:0] tc,      // Terminal count pulses.
    output logic            eop_n    // End of process, active low.
);
    int cnt;

    // One end pulse after LEN busy cycles; the stall models a slow peer.
    // The line idles high, as its pull-up would leave it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            tc <= 2'h0;
            eop_n <= 1'b1;
        end else begin
            tc <= 2'h0;
            eop_n <= 1'b1;
            if (grant == 2'h0 || tc != 2'h0 || !eop_n) begin
                cnt <= 0;
            end else if (!hold) begin
                if (cnt == LEN - 1) begin
                    if (use_eop) begin
                        eop_n <= 1'b0;
                    end else begin
                        tc <= grant;
                    end
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
endmodule

// ### bench/tb_dma_software_request_logic.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Self-checking bench for the software request logic.
// ----------------------------------------------------------------------
module tb_dma_software_request_logic;
    import dsrl_pkg::*;

    logic        clk_sys;
    logic        rst;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [1:0]  dreq;
    logic [1:0]  tc;
    logic        eop_n;
    logic [1:0]  ch_req;
    logic [1:0]  grant;
    logic        hold;
    logic        use_eop;
    logic [7:0]  rv;
    int          n_errors;
    int          num_checks;
    // Rows: write data, pending flags read back, internal requests.
    logic [23:0] rows [5] = '{24'h000000, 24'h040101, 24'h050303,
                              24'h050303, 24'h010303};

    dsrl_top #(.NUM_CH(2)) dut (
        .CLK_SYS(clk_sys), .RESET(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .DREQ(dreq), .TC(tc),
        .END_OF_PROCESS_N(eop_n), .CH_REQ(ch_req), .GRANT(grant)
    );

    dsrl_engine #(.LEN(4)) peer (
        .clk(clk_sys), .rst(rst), .grant(grant), .hold(hold),
        .use_eop(use_eop), .tc(tc), .eop_n(eop_n)
    );

    // ------------------------------------------------------------------
    // Clock, tasks for checks and bus cycles.
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Strobe drops one edge later, so back-to-back calls leave a gap.
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge.
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Bounded wait for a grant value; running out ends the run.
    task automatic wait_grant(input logic [1:0] exp);
        for (int i = 0; i < 20 && grant !== exp; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check("grant", {6'h0, grant}, {6'h0, exp});
        if (grant !== exp) close_out();
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        addr = 16'h0000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        dreq = 2'h3;
        hold = 1'b1;
        use_eop = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(DSRL_SRR_OFF, rv);
        check("srr_reset", rv, 8'h00);
        rd_reg(DSRL_CFG_OFF, rv);
        check("cfg_reset", rv, DSRL_CFG_RST);
        rd_reg(16'hf00f, rv);
        check("unmapped", rv, 8'h00);
        // Table rows; hardware lines are high but masked, engine stalled.
        foreach (rows[i]) begin
            wr_reg(DSRL_SRR_OFF, rows[i][23:16]);
            rd_reg(DSRL_SRR_OFF, rv);
            check("pend", rv, rows[i][15:8]);
            check("ch_req", {6'h0, ch_req}, rows[i][7:0]);
        end
        wait_grant(2'h1);
        repeat (10) @(posedge clk_sys);
        #1;
        check("ch_req_held", {6'h0, ch_req}, 8'h03);
        hold <= 1'b0;
        wait_grant(2'h0);
        wait_grant(2'h2);
        // A second request one cycle before the end is not queued.
        repeat (2) @(posedge clk_sys);
        wr_reg(DSRL_SRR_OFF, 8'h05);
        wait_grant(2'h0);
        repeat (4) @(posedge clk_sys);
        #1;
        check("no_requeue", {4'h0, grant, ch_req}, 8'h00);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_tc", rv, 8'h00);
        // End of process path, with the flag seen while stalled.
        hold <= 1'b1;
        use_eop <= 1'b1;
        wr_reg(DSRL_SRR_OFF, 8'h05);
        wait_grant(2'h2);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_busy", rv, 8'h02);
        hold <= 1'b0;
        wait_grant(2'h0);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_eop", rv, 8'h00);
        use_eop <= 1'b0;
        // Auto-initialize: one end clears both flags.
        wr_reg(DSRL_CFG_OFF, 8'h19);
        hold <= 1'b1;
        wr_reg(DSRL_SRR_OFF, 8'h04);
        wr_reg(DSRL_SRR_OFF, 8'h05);
        wait_grant(2'h1);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_both", rv, 8'h03);
        hold <= 1'b0;
        wait_grant(2'h0);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_auto", rv, 8'h00);
        check("ch_req_auto", {6'h0, ch_req}, 8'h00);
        // Demand mode on channel 0 by hardware; software uses channel 1.
        dreq <= 2'h0;
        wr_reg(DSRL_CFG_OFF, 8'h02);
        hold <= 1'b1;
        dreq <= 2'h1;
        wait_grant(2'h1);
        wr_reg(DSRL_SRR_OFF, 8'h05);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_dem", rv, 8'h02);
        dreq <= 2'h0;
        wait_grant(2'h0);
        wait_grant(2'h2);
        hold <= 1'b0;
        wait_grant(2'h0);
        rd_reg(DSRL_SRR_OFF, rv);
        check("pend_end", rv, 8'h00);
        // Reset in mid-run drops a pending request and its grant.
        hold <= 1'b1;
        wr_reg(DSRL_SRR_OFF, 8'h05);
        wait_grant(2'h2);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check("grant_rst", {6'h0, grant}, 8'h00);
        check("rdata_rst", rdata, 8'h00);
        rd_reg(DSRL_SRR_OFF, rv);
        check("srr_rst", rv, 8'h00);
        rd_reg(DSRL_CFG_OFF, rv);
        check("cfg_rst", rv, DSRL_CFG_RST);
        // A hardware tie goes to channel 0 first after reset, then 1.
        dreq <= 2'h3;
        wr_reg(DSRL_CFG_OFF, 8'h00);
        wait_grant(2'h1);
        rd_reg(DSRL_STAT_OFF, rv);
        check("status", rv, 8'h01);
        hold <= 1'b0;
        wait_grant(2'h0);
        wait_grant(2'h2);
        dreq <= 2'h0;
        wait_grant(2'h0);
        close_out();
    end
endmodule
